// ### hdl/arf_converter_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Result bytes update when the complete flag sets, readable from then on.
// - Single-ended result is unsigned ten bits, zero to all ones.
// - Single-ended code is input times 1024 over reference, from the core.
// - Unipolar differential code is scaled difference times gain 1x or 20x.
// - Unipolar differential code clamps to zero when negative input is higher.
// - Unipolar by default; bipolar bit in control B selects bipolar mode.
// - Bipolar mode yields two's complement code from 0x200 to 0x1FF.
// - Bit nine of a bipolar result is one for negative difference with a nonzero core code; zero code gives 0x000.
// - Channel code 1111 selects and enables the temperature sensor.
// - Selection register: ref bits 7,6,4, adjust bit 5, channel 3:0, reset zero.
// - Reference write during a conversion applies in its last converter cycle, before it completes.
// - After a reference change, next conversion lasts 25 converter clocks.
// - Reference decode: supply, external, 1.1V, reserved, 2.56V, 2.56V bypassed.
// - External selection turns internal reference off; some modes disconnect pin.
// - Adjust bit justifies result left or right, applying immediately.
// - Reading low byte freezes result bytes until high byte is read.
module arf_converter_ctrl
  import arf_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic adcTick,
  input wire logic convStart,
  input wire logic [9:0] coreCode,
  input wire logic coreNegative,
  output logic [3:0] activeChannel,
  output logic [2:0] activeRef,
  output logic tempSensorEn,
  output logic internalRefOn,
  output logic refPinConnect,
  output logic bipolarMode,
  output logic polarityReverse,
  output logic convBusy,
  output logic convDone,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] muxReg, muxNext;
  logic [7:0] ctrlBReg, ctrlBNext;
  logic [3:0] chanReg, chanNext;
  logic [2:0] refReg, refNext;
  logic initPendReg, initPendNext;
  logic [9:0] resultReg, resultNext;
  logic lockReg, lockNext;
  logic [1:0] statReg, statNext;
  logic [1:0] maskReg, maskNext;
  arf_state_t stateReg, stateNext;
  logic [4:0] cntReg, cntNext;
  logic [4:0] lenReg, lenNext;
  logic [31:0] prdataReg, prdataNext;
  logic preadyReg, preadyNext;
  logic slverrReg, slverrNext;
  logic doneReg, doneNext;
  logic [3:0] chOutReg, chOutNext;
  logic [2:0] refOutReg, refOutNext;
  logic tempReg, tempNext;
  logic intOnReg, intOnNext;
  logic pinReg, pinNext;
  logic irqReg, irqNext;

  logic tickS1, tickS2, startS1, startS2;
  logic [9:0] codeS1, codeS2;
  logic negS1, negS2;

  logic [9:0] formCode;
  logic [7:0] lowByte, highByte;
  logic useSupply, useExternal, useInt11, useInt256, intOn, pinOn, refReserved;
  logic [2:0] muxRef;
  logic accessPhase, wrHit, rdHit, latchResult, differential;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; core inputs arrive from the analog side
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tickS1 <= 1'b0;
      tickS2 <= 1'b0;
      startS1 <= 1'b0;
      startS2 <= 1'b0;
      codeS1 <= ARF_CODE_ZERO;
      codeS2 <= ARF_CODE_ZERO;
      negS1 <= 1'b0;
      negS2 <= 1'b0;
    end else begin
      tickS1 <= adcTick;
      tickS2 <= tickS1;
      startS1 <= convStart;
      startS2 <= startS1;
      codeS1 <= coreCode;
      codeS2 <= codeS1;
      negS1 <= coreNegative;
      negS2 <= negS1;
    end
  end

  assign muxRef = {muxReg[ARF_BIT_REF2], muxReg[ARF_BIT_REF1], muxReg[ARF_BIT_REF0]};
  // Channel codes 4..B are the differential pairs
  assign differential = (chanReg[3:2] == 2'b01) || (chanReg[3:2] == 2'b10);
  assign accessPhase = psel && penable && !preadyReg;
  assign wrHit = accessPhase && pwrite;
  assign rdHit = accessPhase && !pwrite;
  // Result lands with the complete flag unless low-byte read holds it
  assign latchResult = (stateReg == ARF_LAST) && tickS2;

  arf_result_format uFormat (
    .rawCode(codeS2),
    .rawNegative(negS2),
    .differential(differential),
    .bipolar(ctrlBReg[ARF_BIT_BIPOLAR]),
    .resultCode(resultReg),
    .leftAdjust(muxReg[ARF_BIT_LADJ]),
    .formCode(formCode),
    .lowByte(lowByte),
    .highByte(highByte)
  );

  arf_ref_decode uRef (
    .refSel(refReg),
    .useSupply(useSupply),
    .useExternal(useExternal),
    .useInt11(useInt11),
    .useInt256(useInt256),
    .internalOn(intOn),
    .refPinConnect(pinOn),
    .refReserved(refReserved)
  );

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencer and the shadowed channel/reference selection
  always_comb begin
    stateNext = stateReg;
    cntNext = cntReg;
    lenNext = lenReg;
    chanNext = chanReg;
    refNext = refReg;
    initPendNext = initPendReg;
    doneNext = 1'b0;
    // Selection tracks the register except while a conversion is locked
    if (stateReg != ARF_CONV) begin
      chanNext = muxReg[3:0];
      refNext = muxRef;
      if (muxRef != refReg) begin
        initPendNext = 1'b1;
      end
    end
    unique case (stateReg)
      ARF_IDLE: begin
        if (startS2) begin
          stateNext = ARF_CONV;
          cntNext = 5'h01;
          // A pending reference change stretches this conversion
          lenNext = (initPendNext || muxRef != refReg) ? ARF_LEN_INIT : ARF_LEN_NORMAL;
          initPendNext = 1'b0;
        end
      end
      ARF_CONV: begin
        if (tickS2) begin
          cntNext = cntReg + 5'h01;
          // Update resumes in the last converter cycle
          if (cntNext == lenReg) begin
            stateNext = ARF_LAST;
          end
        end
      end
      ARF_LAST: begin
        if (tickS2) begin
          stateNext = ARF_IDLE;
          doneNext = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stateReg <= ARF_IDLE;
      cntReg <= 5'h00;
      lenReg <= ARF_LEN_INIT;
      chanReg <= 4'h0;
      refReg <= 3'h0;
      initPendReg <= 1'b1;
      doneReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      cntReg <= cntNext;
      lenReg <= lenNext;
      chanReg <= chanNext;
      refReg <= refNext;
      initPendReg <= initPendNext;
      doneReg <= doneNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers, result hold and interrupt status
  always_comb begin
    muxNext = muxReg;
    ctrlBNext = ctrlBReg;
    maskNext = maskReg;
    statNext = statReg;
    resultNext = resultReg;
    lockNext = lockReg;
    prdataNext = prdataReg;
    slverrNext = 1'b0;
    preadyNext = accessPhase;
    if (wrHit) begin
      unique case (paddr)
        ARF_ADDR_MUX: muxNext = pwdata[7:0];
        ARF_ADDR_CTRL_B: ctrlBNext = pwdata[7:0];
        ARF_ADDR_IRQ_MASK: maskNext = pwdata[1:0];
        ARF_ADDR_IRQ_STAT: statNext = statReg & ~pwdata[1:0];
        ARF_ADDR_RES_LOW, ARF_ADDR_RES_HIGH, ARF_ADDR_STATUS: ;
        default: slverrNext = 1'b1;
      endcase
    end
    if (rdHit) begin
      prdataNext = 32'h0000_0000;
      unique case (paddr)
        ARF_ADDR_MUX: prdataNext[7:0] = muxReg;
        ARF_ADDR_CTRL_B: prdataNext[7:0] = ctrlBReg;
        ARF_ADDR_IRQ_MASK: prdataNext[1:0] = maskReg;
        ARF_ADDR_IRQ_STAT: prdataNext[1:0] = statReg;
        ARF_ADDR_STATUS: prdataNext[3:0] = {refReserved, initPendReg, lockReg, stateReg != ARF_IDLE};
        ARF_ADDR_RES_LOW: begin
          prdataNext[7:0] = lowByte;
          lockNext = 1'b1;
        end
        ARF_ADDR_RES_HIGH: begin
          prdataNext[7:0] = highByte;
          lockNext = 1'b0;
        end
        default: slverrNext = 1'b1;
      endcase
    end
    // Result frozen between low and high reads, a low read in this cycle included
    if (latchResult && !lockNext) begin
      resultNext = formCode;
    end
    // Events set after the clear so a coincident set wins
    if (latchResult) begin
      statNext[ARF_IRQ_DONE] = 1'b1;
    end
    if (stateReg == ARF_IDLE && muxRef != refReg) begin
      statNext[ARF_IRQ_REFCHG] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      muxReg <= ARF_MUX_RESET;
      ctrlBReg <= 8'h00;
      maskReg <= 2'b00;
      statReg <= 2'b00;
      resultReg <= ARF_CODE_ZERO;
      lockReg <= 1'b0;
      prdataReg <= 32'h0000_0000;
      preadyReg <= 1'b0;
      slverrReg <= 1'b0;
    end else begin
      muxReg <= muxNext;
      ctrlBReg <= ctrlBNext;
      maskReg <= maskNext;
      statReg <= statNext;
      resultReg <= resultNext;
      lockReg <= lockNext;
      prdataReg <= prdataNext;
      preadyReg <= preadyNext;
      slverrReg <= slverrNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs toward the analog side
  always_comb begin
    chOutNext = chanReg;
    refOutNext = refReg;
    tempNext = (chanReg == ARF_CH_TEMP);
    intOnNext = intOn;
    pinNext = pinOn;
    irqNext = |(statNext & maskNext);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      chOutReg <= 4'h0;
      refOutReg <= 3'h0;
      tempReg <= 1'b0;
      intOnReg <= 1'b0;
      pinReg <= 1'b0;
      irqReg <= 1'b0;
    end else begin
      chOutReg <= chOutNext;
      refOutReg <= refOutNext;
      tempReg <= tempNext;
      intOnReg <= intOnNext;
      pinReg <= pinNext;
      irqReg <= irqNext;
    end
  end

  assign prdata = prdataReg;
  assign pready = preadyReg;
  assign pslverr = slverrReg;
  assign activeChannel = chOutReg;
  assign activeRef = refOutReg;
  assign tempSensorEn = tempReg;
  assign internalRefOn = intOnReg;
  assign refPinConnect = pinReg;
  assign bipolarMode = ctrlBReg[ARF_BIT_BIPOLAR];
  assign polarityReverse = ctrlBReg[ARF_BIT_POLREV];
  assign convBusy = (stateReg != ARF_IDLE);
  assign convDone = doneReg;
  assign irq = irqReg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_lowRead;
    rdHit && paddr == ARF_ADDR_RES_LOW;
  endsequence

  a_ref_locked_conv: assert property (@(posedge clk) disable iff (!resetn)
    stateReg == ARF_CONV ##1 stateReg == ARF_CONV |-> $stable(refReg))
    else $error("reference changed mid conversion");
  a_long_after_change: assert property (@(posedge clk) disable iff (!resetn)
    stateReg == ARF_IDLE && startS2 && (initPendReg || muxRef != refReg) |=> lenReg == ARF_LEN_INIT)
    else $error("conversion after reference change not extended");
  a_hold_after_low: assert property (@(posedge clk) disable iff (!resetn)
    s_lowRead |=> lockReg && $stable(resultReg))
    else $error("result changed after low byte read");
  a_temp_enable: assert property (@(posedge clk) disable iff (!resetn)
    chanReg == ARF_CH_TEMP |=> tempSensorEn)
    else $error("temperature sensor not enabled");
  a_ext_int_off: assert property (@(posedge clk) disable iff (!resetn)
    refReg[1:0] == 2'b01 |=> !internalRefOn && refPinConnect)
    else $error("internal reference on with external selected");
  a_unipolar_clamp: assert property (@(posedge clk) disable iff (!resetn)
    latchResult && !lockNext && differential && !ctrlBReg[ARF_BIT_BIPOLAR] && negS2
    |=> resultReg == ARF_CODE_ZERO)
    else $error("negative unipolar difference not clamped");
  a_bipolar_sign: assert property (@(posedge clk) disable iff (!resetn)
    latchResult && !lockNext && differential && ctrlBReg[ARF_BIT_BIPOLAR] && negS2 && codeS2 != ARF_CODE_ZERO
    |=> resultReg[9])
    else $error("bipolar sign bit wrong");
  a_done_sets_flag: assert property (@(posedge clk) disable iff (!resetn)
    latchResult |=> statReg[ARF_IRQ_DONE] && convDone)
    else $error("completion flag not set");
  a_adjust_high: assert property (@(posedge clk) disable iff (!resetn)
    rdHit && paddr == ARF_ADDR_RES_HIGH && muxReg[ARF_BIT_LADJ] |=> prdata[7:0] == $past(resultReg[9:2]))
    else $error("left adjust not applied");
endmodule

// ### hdl/arf_pkg.sv
package arf_pkg;
  // Register word addresses (byte address = index * 4; printed offsets are not multiples of four)
  localparam logic [7:0] ARF_IDX_MUX = 8'h07;
  localparam logic [7:0] ARF_IDX_RES_LOW = 8'h04;
  localparam logic [7:0] ARF_IDX_RES_HIGH = 8'h05;
  localparam logic [7:0] ARF_IDX_CTRL_B = 8'h03;
  localparam logic [7:0] ARF_IDX_IRQ_STAT = 8'h08;
  localparam logic [7:0] ARF_IDX_IRQ_MASK = 8'h09;
  localparam logic [7:0] ARF_IDX_STATUS = 8'h0A;
  localparam logic [11:0] ARF_ADDR_MUX = 12'h01C;
  localparam logic [11:0] ARF_ADDR_RES_LOW = 12'h010;
  localparam logic [11:0] ARF_ADDR_RES_HIGH = 12'h014;
  localparam logic [11:0] ARF_ADDR_CTRL_B = 12'h00C;
  localparam logic [11:0] ARF_ADDR_IRQ_STAT = 12'h020;
  localparam logic [11:0] ARF_ADDR_IRQ_MASK = 12'h024;
  localparam logic [11:0] ARF_ADDR_STATUS = 12'h028;
  // Selection register fields
  localparam int ARF_BIT_REF1 = 7;
  localparam int ARF_BIT_REF0 = 6;
  localparam int ARF_BIT_LADJ = 5;
  localparam int ARF_BIT_REF2 = 4;
  localparam logic [7:0] ARF_MUX_RESET = 8'h00;
  localparam logic [3:0] ARF_CH_TEMP = 4'hF;
  // Control B fields
  localparam int ARF_BIT_BIPOLAR = 7;
  localparam int ARF_BIT_POLREV = 5;
  // Reference selection codes
  localparam logic [2:0] ARF_REF_INT11 = 3'h2;
  localparam logic [2:0] ARF_REF_RSVD = 3'h3;
  localparam logic [2:0] ARF_REF_INT256 = 3'h6;
  localparam logic [2:0] ARF_REF_INT256BP = 3'h7;
  // Conversion lengths in converter clock cycles
  localparam logic [4:0] ARF_LEN_NORMAL = 5'h0D;
  localparam logic [4:0] ARF_LEN_INIT = 5'h19;
  localparam logic [9:0] ARF_CODE_MAX = 10'h3FF;
  localparam logic [9:0] ARF_CODE_ZERO = 10'h000;
  // Ends of the bipolar two's complement range
  localparam logic [9:0] ARF_BIP_NEG_FULL = 10'h200;
  localparam logic [9:0] ARF_BIP_POS_FULL = 10'h1FF;
  // Interrupt status bits
  localparam int ARF_IRQ_DONE = 0;
  localparam int ARF_IRQ_REFCHG = 1;
  typedef enum logic [1:0] {ARF_IDLE = 2'b00, ARF_CONV = 2'b01, ARF_LAST = 2'b11} arf_state_t;
endpackage

// ### hdl/arf_ref_decode.sv
`timescale 1ns/1ps
module arf_ref_decode
  import arf_pkg::*;
(
  input wire logic [2:0] refSel,
  output logic useSupply,
  output logic useExternal,
  output logic useInt11,
  output logic useInt256,
  output logic internalOn,
  output logic refPinConnect,
  output logic refReserved
);
  // Low two bits pick supply or external regardless of bit 2
  always_comb begin
    useSupply = (refSel[1:0] == 2'b00);
    useExternal = (refSel[1:0] == 2'b01);
    useInt11 = (refSel == ARF_REF_INT11);
    useInt256 = (refSel == ARF_REF_INT256) || (refSel == ARF_REF_INT256BP);
    refReserved = (refSel == ARF_REF_RSVD);
    internalOn = useInt11 || useInt256;
    // Pin only tied in when it carries or bypasses the reference
    refPinConnect = useExternal || (refSel == ARF_REF_INT256BP);
  end
endmodule

// ### hdl/arf_result_format.sv
`timescale 1ns/1ps
module arf_result_format
  import arf_pkg::*;
(
  input wire logic [9:0] rawCode,
  input wire logic rawNegative,
  input wire logic differential,
  input wire logic bipolar,
  input wire logic [9:0] resultCode,
  input wire logic leftAdjust,
  output logic [9:0] formCode,
  output logic [7:0] lowByte,
  output logic [7:0] highByte
);
  // Core code: magnitude from scaling, sign from the comparator
  always_comb begin
    if (differential && bipolar) begin
      // Core magnitude can overrun the signed range; saturate so the sign never flips
      if (rawNegative) begin
        formCode = (rawCode > ARF_BIP_NEG_FULL) ? ARF_BIP_NEG_FULL : (~rawCode + 10'h001);
      end else begin
        formCode = (rawCode > ARF_BIP_POS_FULL) ? ARF_BIP_POS_FULL : rawCode;
      end
    end else if (differential && rawNegative) begin
      formCode = ARF_CODE_ZERO;
    end else begin
      formCode = rawCode;
    end
  end

  // Justification follows the adjust bit at once, even mid conversion
  always_comb begin
    if (leftAdjust) begin
      highByte = resultCode[9:2];
      lowByte = {resultCode[1:0], 6'h00};
    end else begin
      highByte = {6'h00, resultCode[9:8]};
      lowByte = resultCode[7:0];
    end
  end
endmodule

// ### verification/arf_core_model.sv
`timescale 1ns/1ps
module arf_core_model
  import arf_pkg::*;
#(
  parameter int VSUP = 5000,
  parameter int VEXT = 3000
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] activeChannel,
  input wire logic [2:0] activeRef,
  input wire logic bipolarMode,
  input wire logic convBusy,
  input wire logic signed [15:0] vPos,
  input wire logic signed [15:0] vNeg,
  input wire logic [3:0] tickDiv,
  output logic adcTick,
  output logic [9:0] coreCode,
  output logic coreNegative
);
  int cnt = 0;
  int vref, diff, mag;
  logic isDiff, neg;
  logic [9:0] code;
  ////////////////////////////////////////////////////////////
  // Prescaler strobe, free running as the real divider
  initial adcTick = 1'b0;
  always @(posedge clk) begin
    cnt <= (!resetn || cnt + 1 >= tickDiv) ? 0 : cnt + 1;
    adcTick <= resetn && (cnt + 1 >= tickDiv);
  end
  ////////////////////////////////////////////////////////////
  // Ideal core transfer; outside a conversion the lines show the inverse
  always_comb begin
    isDiff = activeChannel inside {[4'h4:4'hB]};
    vref = (activeRef[1:0] == 2'b00) ? VSUP : (activeRef[1:0] == 2'b01) ? VEXT : activeRef[2] ? 2560 : 1100;
    diff = isDiff ? int'(vPos) - int'(vNeg) : int'(vPos);
    mag = (diff < 0 ? -diff : diff) * ((isDiff && bipolarMode) ? 512 : 1024) * ((isDiff && activeChannel[0]) ? 20 : 1)
      / vref;
    if (mag > 1023) mag = 1023;
    code = mag[9:0];
    neg = isDiff && diff < 0;
    coreCode = convBusy ? code : ~code;
    coreNegative = convBusy ? neg : ~neg;
  end
endmodule

// ### verification/tb_adc_result_format_and_ref_select.sv
`timescale 1ns/1ps
module tb_adc_result_format_and_ref_select
  import arf_pkg::*;
;
  localparam int VSUP = 5000;
  localparam int VEXT = 3000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] paddr = '0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, convStart = 1'b0;
  logic [31:0] pwdata = '0;
  logic signed [15:0] vPos = '0, vNeg = '0;
  logic [3:0] tickDiv = 4'h1;
  logic [31:0] prdata;
  logic pready, pslverr, adcTick, coreNegative, tempSensorEn, internalRefOn, refPinConnect;
  logic bipolarMode, polarityReverse, convBusy, convDone, irq;
  logic [9:0] coreCode;
  logic [3:0] activeChannel;
  logic [2:0] activeRef;
  int fail_count = 0, tests_run = 0, seed = 50, busyCnt = 0, mdlRes = 0;
  int busyLen[12];
  logic [7:0] mdlMux = 8'h00;
  logic mdlLock = 1'b0;
  // Cases: selection, control B, inputs in millivolts; temperature on 1.1V, gain on external
  logic [7:0] tMux[12] = '{8'h8F, 8'h8F, 8'h8F, 8'h42, 8'h46, 8'h47, 8'h46, 8'h46, 8'h47, 8'h46, 8'h46, 8'h46};
  logic [7:0] tCtl[12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'hA0, 8'h80, 8'h80, 8'h80};
  int tVp[12] = '{300, 1099, 550, 0, 2000, 600, 500, 500, 550, 0, 2000, 2000};
  int tVn[12] = '{0, 0, 0, 0, 500, 500, 2000, 2000, 500, 3000, 500, 500};
  ////////////////////////////////////////////////////////////
  // Clock, design, analog side
  initial begin
    forever #2.5 clk = ~clk;
  end
  arf_converter_ctrl DUT (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .adcTick(adcTick),
    .convStart(convStart), .coreCode(coreCode), .coreNegative(coreNegative), .activeChannel(activeChannel),
    .activeRef(activeRef), .tempSensorEn(tempSensorEn), .internalRefOn(internalRefOn),
    .refPinConnect(refPinConnect), .bipolarMode(bipolarMode), .polarityReverse(polarityReverse),
    .convBusy(convBusy), .convDone(convDone), .irq(irq));
  arf_core_model #(.VSUP(VSUP), .VEXT(VEXT)) core (.clk(clk), .resetn(resetn), .activeChannel(activeChannel),
    .activeRef(activeRef), .bipolarMode(bipolarMode), .convBusy(convBusy), .vPos(vPos), .vNeg(vNeg),
    .tickDiv(tickDiv), .adcTick(adcTick), .coreCode(coreCode), .coreNegative(coreNegative));
  // Busy length, read only while the sequencer is idle
  always @(posedge clk) begin
    if (convBusy === 1'b1) busyCnt <= busyCnt + 1;
  end
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Every wait is bounded; running out ends the run
  task automatic bound(input int n, input int lim, input string what);
    if (n >= lim) begin
      fail_count++;
      $display("CHECK FAILED %s wait expected below %0d seen %0d", what, lim, n);
      report_and_stop();
    end
  endtask
  // One APB transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    bound(n, 20, "bus answer");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic regWr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    if (a == ARF_ADDR_MUX) mdlMux = d[7:0];
  endtask
  // Read compared with the model; low byte locks, high byte frees
  task automatic regRd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk($sformatf("read %h", a), exp & m, q & m);
    if (a == ARF_ADDR_RES_LOW) mdlLock = 1'b1;
    if (a == ARF_ADDR_RES_HIGH) mdlLock = 1'b0;
  endtask
  function automatic logic [7:0] resByte(input logic hi);
    logic [9:0] r;
    r = mdlRes[9:0];
    if (mdlMux[5]) return hi ? r[9:2] : {r[1:0], 6'h00};
    return hi ? {6'h00, r[9:8]} : r[7:0];
  endfunction
  function automatic int expCode(input logic [3:0] ch, input logic [2:0] rf, input logic bip, input int vp, input int vn);
    int vref, d, m;
    logic df;
    df = ch inside {[4'h4:4'hB]};
    vref = (rf[1:0] == 2'b00) ? VSUP : (rf[1:0] == 2'b01) ? VEXT : rf[2] ? 2560 : 1100;
    d = df ? vp - vn : vp;
    m = (d < 0 ? -d : d) * ((df && bip) ? 512 : 1024) * ((df && ch[0]) ? 20 : 1) / vref;
    if (df && bip) return ((d < 0) ? 1024 - (m > 512 ? 512 : m) : (m > 511 ? 511 : m)) & 1023;
    return (d < 0) ? 0 : (m > 1023 ? 1023 : m);
  endfunction
  // One conversion from the table, then flags, interrupt and both justifications
  task automatic conv(input int i);
    int n, b0, e;
    e = expCode(tMux[i][3:0], {tMux[i][4], tMux[i][7:6]}, tCtl[i][7], tVp[i], tVn[i]);
    tickDiv <= (i < 4) ? 4'h1 : 4'h3;
    regWr(ARF_ADDR_CTRL_B, {24'h0, tCtl[i]});
    regWr(ARF_ADDR_MUX, {24'h0, tMux[i]});
    regWr(ARF_ADDR_IRQ_MASK, (i == 6) ? 32'h0 : 32'h1);
    if (i == 10) regRd(ARF_ADDR_RES_LOW, resByte(0), 8'hFF);
    vPos <= 16'(tVp[i]);
    vNeg <= 16'(tVn[i]);
    convStart <= 1'b1;
    b0 = busyCnt;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (convBusy !== 1'b1 && n < 50);
    bound(n, 50, "conversion start");
    convStart <= 1'b0;
    if (i == 2) begin
      regWr(ARF_ADDR_MUX, 32'h0000_0042);
      chk("ref held in conversion", 3'h2, activeRef);
    end
    n = 0;
    while (convDone !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    bound(n, 500, "conversion end");
    if (!mdlLock) mdlRes = e;
    repeat (2) @(posedge clk);
    busyLen[i] = busyCnt - b0;
    chk("ref in use", {mdlMux[4], mdlMux[7:6]}, activeRef);
    chk("bipolar output", tCtl[i][7], bipolarMode);
    chk("reversal output", tCtl[i][5], polarityReverse);
    chk("interrupt", i != 6, irq);
    regRd(ARF_ADDR_IRQ_STAT, 1, 8'h01);
    regWr(ARF_ADDR_IRQ_STAT, 32'h0000_0003);
    regRd(ARF_ADDR_IRQ_STAT, 0, 8'h03);
    chk("interrupt cleared", 0, irq);
    regRd(ARF_ADDR_RES_LOW, resByte(0), 8'hFF);
    regRd(ARF_ADDR_RES_HIGH, resByte(1), 8'hFF);
    regWr(ARF_ADDR_MUX, {24'h0, mdlMux | 8'h20});
    regRd(ARF_ADDR_RES_LOW, resByte(0), 8'hFF);
    regRd(ARF_ADDR_RES_HIGH, resByte(1), 8'hFF);
    regWr(ARF_ADDR_MUX, {24'h0, mdlMux & 8'hDF});
    $display("test conversion %0d done", i);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] q;
    logic e;
    logic [4:0] r;
    logic [7:0] v;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    regRd(ARF_ADDR_MUX, 0, 8'hFF);
    regWr(ARF_ADDR_RES_HIGH, 32'h0000_00FF);
    regRd(ARF_ADDR_RES_LOW, 0, 8'hFF);
    regRd(ARF_ADDR_RES_HIGH, 0, 8'hFF);
    regRd(ARF_ADDR_CTRL_B, 0, 8'hA0);
    apb(1'b0, 12'h0FC, 32'h0, q, e);
    chk("unmapped error", 1, e);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      r = 5'($random(seed));
      v = {k[1], k[0], r[4], k[2], (k == 2) ? 4'hF : r[3:0]};
      regWr(ARF_ADDR_MUX, {24'h0, v});
      regRd(ARF_ADDR_MUX, v, 8'hFF);
      chk("ref in use", k, activeRef);
      chk("channel in use", v[3:0], activeChannel);
      chk("temp sensor", v[3:0] == 4'hF, tempSensorEn);
      if (k % 4 == 1) chk("internal ref", 0, internalRefOn);
      if (k == 2 || k >= 6) chk("internal ref", 1, internalRefOn);
      if (k % 4 == 0 || k == 6) chk("ref pin", 0, refPinConnect);
      if (k % 4 == 1 || k == 7) chk("ref pin", 1, refPinConnect);
    end
    regRd(ARF_ADDR_IRQ_STAT, 2, 8'h02);
    regWr(ARF_ADDR_IRQ_STAT, 32'h0000_0003);
    $display("test selection decode done");
    for (int i = 0; i < 12; i++) conv(i);
    chk("first length", 12, busyLen[0] - busyLen[1]);
    chk("plain length", busyLen[1], busyLen[2]);
    chk("length after ref change", 12, busyLen[3] - busyLen[2]);
    $display("test conversion lengths done");
    report_and_stop();
  end
endmodule
